// ===== ddc_pkg.sv
// Operation
// - Independent trigger loads only that channel's output three clocks after its trigger.
// - Triangle mode adds counter to holding value, stores sum, then advances counter.
// - Each channel's triangle uses its own four-bit amplitude field.
// - Wave select with upper bit one enables triangle; lower bit ignored.
// - Wave select 01 enables noise, shift register masked by the four-bit field.
// - Noise mode adds own masked shifter to holding value, stores, then advances shifter.
// - Both trigger enables clear: dual holding write loads both outputs one clock later.
// - Same hardware trigger line on both channels loads both outputs together three clocks later; software select loads each channel on its own SWTRIG bit.
// - Shared-trigger noise mode loads both masked sums together, then advances both shifters.
// - Shared-trigger triangle mode loads both sums together, then advances both counters.
// - Noise shifter starts from 0xAAA whenever noise generation begins.
// - An all-zero noise shifter gets a one injected so it cannot lock up.
// - Triangle counts up below amplitude, down to zero, then up again, forever.
// - Holding value plus wave value is formed without overflow before storing.
package ddc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SWTRIG = 8'h04;
  localparam logic [7:0] OFF_D12R = 8'h20;
  localparam logic [7:0] OFF_D12L = 8'h24;
  localparam logic [7:0] OFF_D8R = 8'h28;
  localparam logic [7:0] OFF_OUT1 = 8'h2C;
  localparam logic [7:0] OFF_OUT2 = 8'h30;
  localparam int CH_STRIDE = 16;
  localparam int TEN_POS = 2;
  localparam int TSEL_LSB = 3;
  localparam int WAVE_LSB = 6;
  localparam int MAMP_LSB = 8;
  localparam logic [31:0] CTRL_WMASK = 32'h0FFC_0FFC;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] TSEL_SOFTWARE = 3'h7;
  localparam logic [1:0] WAVE_OFF = 2'h0;
  localparam logic [1:0] WAVE_NOISE = 2'h1;
  localparam logic [11:0] LFSR_PRESET = 12'hAAA;
  localparam logic [11:0] MAX_CODE = 12'hFFF;
  localparam logic [3:0] MAMP_TOP = 4'hB;
  localparam int TRIG_DELAY_CYCLES = 3;
  localparam int HOLD_DELAY_CYCLES = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [11:0] unmask(input logic [3:0] mamp);
    logic [3:0] n;
    logic [12:0] t;
    n = (mamp > MAMP_TOP) ? MAMP_TOP : mamp;
    t = (13'h0002 << n) - 13'h0001;
    return t[11:0];
  endfunction

  function automatic logic [11:0] satAdd(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[12] ? MAX_CODE : s[11:0];
  endfunction

  function automatic logic [11:0] lfsrStep(input logic [11:0] v);
    logic [11:0] n;
    n = {v[10:0], v[11] ^ v[5] ^ v[3] ^ v[0]};
    if (n == 12'h000) begin
      n = 12'h001;
    end
    return n;
  endfunction

  function automatic logic [31:0] strobeMask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
endpackage

// ===== ddc_ch_if.sv
`timescale 1ns/1ps
interface ddc_ch_if;
  logic load;
  logic [1:0] wave;
  logic [3:0] maskAmp;
  logic [11:0] hold;
  logic [11:0] outValue;
  modport ctrl(output load, output wave, output maskAmp, output hold, input outValue);
  modport chan(input load, input wave, input maskAmp, input hold, output outValue);
endinterface

// ===== ddc_channel.sv
`timescale 1ns/1ps
module ddc_channel
  import ddc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  ddc_ch_if.chan ch
);
  typedef struct packed {
    logic [11:0] noise;
    logic [11:0] triCount;
    logic triDown;
    logic [11:0] outv;
  } ddc_chan_state_type;

  ddc_chan_state_type state_ff;
  ddc_chan_state_type nxt_state;
  logic [11:0] ampMask;
  logic [11:0] addend;
  logic isTriangle;
  logic isNoise;
  logic goDown;

  assign ampMask = unmask(ch.maskAmp);
  assign isTriangle = ch.wave[1];
  assign isNoise = (ch.wave == WAVE_NOISE);
  assign addend = isTriangle ? state_ff.triCount : (isNoise ? (state_ff.noise & ampMask) : 12'h000);
  assign goDown = state_ff.triDown ? (state_ff.triCount != 12'h000) : (state_ff.triCount >= ampMask);
  assign ch.outValue = state_ff.outv;

  always_comb begin
    nxt_state = state_ff;
    // Clearing the wave field restarts the triangle from zero, counting up.
    if (ch.wave == WAVE_OFF) begin
      nxt_state.triCount = 12'h000;
      nxt_state.triDown = 1'b0;
    end
    // The shifter rests at its preset outside noise mode, so a switch from triangle straight to noise starts fresh.
    if (!isNoise) begin
      nxt_state.noise = LFSR_PRESET;
    end
    if (ch.load) begin
      // The sum uses the generator value before it steps, so the step lands afterwards.
      nxt_state.outv = satAdd(ch.hold, addend);
      if (isTriangle) begin
        nxt_state.triDown = goDown;
        nxt_state.triCount = goDown ? state_ff.triCount - 12'h001 : state_ff.triCount + 12'h001;
      end else if (isNoise) begin
        nxt_state.noise = lfsrStep(state_ff.noise);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.noise <= LFSR_PRESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  chk_tri_sum: assert property (@(posedge clock) disable iff (rst)
    (ch.load && ch.wave[1]) |=> (ch.outValue == satAdd($past(ch.hold), $past(state_ff.triCount))))
    else $error("triangle sum not stored on load");

  chk_noise_sum: assert property (@(posedge clock) disable iff (rst)
    (ch.load && ch.wave == WAVE_NOISE) |=>
      (ch.outValue == satAdd($past(ch.hold), $past(state_ff.noise) & $past(ampMask)))
      && (state_ff.noise == lfsrStep($past(state_ff.noise))))
    else $error("noise sum or shifter step wrong");

  chk_lfsr_preset: assert property (@(posedge clock) disable iff (rst)
    (ch.wave == WAVE_OFF) |=> (state_ff.noise == LFSR_PRESET) && (state_ff.triCount == 12'h000))
    else $error("generators not preset while wave off");

  chk_lfsr_nolock: assert property (@(posedge clock) disable iff (rst)
    1'b1 |-> (state_ff.noise != 12'h000))
    else $error("noise shifter locked at zero");

  chk_tri_turn: assert property (@(posedge clock) disable iff (rst)
    (ch.load && ch.wave[1] && !state_ff.triDown && state_ff.triCount >= ampMask && state_ff.triCount != 12'h000)
      |=> state_ff.triDown && (state_ff.triCount == $past(state_ff.triCount) - 12'h001))
    else $error("triangle did not turn at amplitude");

  chk_clamp_top: assert property (@(posedge clock) disable iff (rst)
    (ch.load && (({1'b0, ch.hold} + {1'b0, addend}) > {1'b0, MAX_CODE})) |=> (ch.outValue == MAX_CODE))
    else $error("output wrapped instead of clamping");
endmodule

// ===== ddc_top.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ddc_top
  import ddc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] triggerIn,
  output logic [11:0] ch1OutputValue,
  output logic [11:0] ch2OutputValue
);
  typedef struct packed {
    logic [ADDR_W-1:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] ctrl;
    logic [1:0] swTrig;
    logic [1:0][11:0] hold;
    logic holdPend;
    logic [7:0] trigPrev;
    logic [1:0] pipeA;
    logic [1:0] pipeB;
  } ddc_top_state_type;

  ddc_top_state_type state_ff;
  ddc_top_state_type nxt_state;
  logic [1:0] ten;
  logic [1:0] swSel;
  logic [1:0] edgeSel;
  logic [1:0] loadCh;
  logic [1:0][2:0] tselCh;
  logic [1:0][1:0] waveCh;
  logic [1:0][11:0] outVals;
  logic [7:0] edges;
  logic doWrite;
  logic holdWrite;
  logic isHoldAddr;

  // Line 7 of the trigger vector is never used: select code 7 means the software trigger.
  assign edges = triggerIn & ~state_ff.trigPrev;
  assign doWrite = state_ff.awHeld && state_ff.wHeld;
  assign isHoldAddr = (state_ff.awAddr == OFF_D12R) || (state_ff.awAddr == OFF_D12L) ||
                      (state_ff.awAddr == OFF_D8R);
  // Only full-word writes update the holding values, since a partial write would split a sample.
  assign holdWrite = doWrite && isHoldAddr && (state_ff.wStrb == 4'hF);

  for (genvar c = 0; c < 2; c++) begin : chGen
    localparam int BASE = c * CH_STRIDE;
    ddc_ch_if chIf();
    assign ten[c] = state_ff.ctrl[BASE + TEN_POS];
    assign tselCh[c] = state_ff.ctrl[BASE + TSEL_LSB +: 3];
    assign waveCh[c] = state_ff.ctrl[BASE + WAVE_LSB +: 2];
    assign swSel[c] = (tselCh[c] == TSEL_SOFTWARE);
    assign edgeSel[c] = edges[tselCh[c]];
    // Each channel picks its own trigger path; equal line selects make the loads coincide, but software loads follow each channel's own bit.
    assign loadCh[c] = ten[c] ? (swSel[c] ? state_ff.swTrig[c] : state_ff.pipeB[c])
                              : state_ff.holdPend;
    assign chIf.load = loadCh[c];
    // Wave generation is only honoured while the trigger is enabled.
    assign chIf.wave = ten[c] ? waveCh[c] : WAVE_OFF;
    assign chIf.maskAmp = state_ff.ctrl[BASE + MAMP_LSB +: 4];
    assign chIf.hold = state_ff.hold[c];
    assign outVals[c] = chIf.outValue;
    ddc_channel uChannel (
      .clock(clock),
      .rst(rst),
      .ch(chIf)
    );
  end

  assign ch1OutputValue = outVals[0];
  assign ch2OutputValue = outVals[1];
  assign s_axi_awready = !state_ff.awHeld && !state_ff.bValid;
  assign s_axi_wready = !state_ff.wHeld && !state_ff.bValid;
  assign s_axi_bvalid = state_ff.bValid;
  assign s_axi_bresp = state_ff.bResp;
  assign s_axi_arready = !state_ff.rValid;
  assign s_axi_rvalid = state_ff.rValid;
  assign s_axi_rdata = state_ff.rData;
  assign s_axi_rresp = state_ff.rResp;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.trigPrev = triggerIn;
    // Two stages plus the output register give the three-clock trigger latency.
    nxt_state.pipeA = ten & ~swSel & edgeSel;
    nxt_state.pipeB = state_ff.pipeA;
    // A software trigger is consumed the clock after it is written, so it always self-clears.
    nxt_state.swTrig = 2'b00;
    nxt_state.holdPend = holdWrite;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_state.awHeld = 1'b1;
      nxt_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_state.wHeld = 1'b1;
      nxt_state.wData = s_axi_wdata;
      nxt_state.wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      nxt_state.bValid = 1'b0;
    end
    if (doWrite) begin
      nxt_state.awHeld = 1'b0;
      nxt_state.wHeld = 1'b0;
      nxt_state.bValid = 1'b1;
      nxt_state.bResp = RESP_OKAY;
      unique case (state_ff.awAddr)
        OFF_CTRL: begin
          nxt_state.ctrl = (state_ff.ctrl & ~strobeMask(state_ff.wStrb)) |
                           (state_ff.wData & strobeMask(state_ff.wStrb) & CTRL_WMASK);
        end
        OFF_SWTRIG: begin
          if (state_ff.wStrb[0]) begin
            nxt_state.swTrig = state_ff.wData[1:0];
          end
        end
        OFF_D12R: begin
          if (holdWrite) begin
            nxt_state.hold = {state_ff.wData[27:16], state_ff.wData[11:0]};
          end
        end
        OFF_D12L: begin
          if (holdWrite) begin
            nxt_state.hold = {state_ff.wData[31:20], state_ff.wData[15:4]};
          end
        end
        OFF_D8R: begin
          if (holdWrite) begin
            nxt_state.hold = {state_ff.wData[15:8], 4'h0, state_ff.wData[7:0], 4'h0};
          end
        end
        OFF_OUT1, OFF_OUT2: begin
        end
        default: begin
          nxt_state.bResp = RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nxt_state.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_state.rValid = 1'b1;
      nxt_state.rResp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL: nxt_state.rData = state_ff.ctrl;
        OFF_SWTRIG: nxt_state.rData = {30'h0, state_ff.swTrig};
        OFF_D12R: nxt_state.rData = {4'h0, state_ff.hold[1], 4'h0, state_ff.hold[0]};
        OFF_D12L: nxt_state.rData = {state_ff.hold[1], 4'h0, state_ff.hold[0], 4'h0};
        OFF_D8R: nxt_state.rData = {16'h0, state_ff.hold[1][11:4], state_ff.hold[0][11:4]};
        OFF_OUT1: nxt_state.rData = {20'h0, outVals[0]};
        OFF_OUT2: nxt_state.rData = {20'h0, outVals[1]};
        default: begin
          nxt_state.rData = 32'h0000_0000;
          nxt_state.rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.ctrl <= CTRL_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  sequence seqLoadAfterTrig(logic l);
    ##2 l;
  endsequence

  sequence seqBothLoaded;
    ##2 (loadCh == 2'b11);
  endsequence

  chk_indep_delay: assert property (@(posedge clock) disable iff (rst)
    (ten[0] && !swSel[0] && edgeSel[0]) |-> seqLoadAfterTrig(loadCh[0]))
    else $error("channel 1 trigger did not load after three clocks");

  chk_indep_ch2: assert property (@(posedge clock) disable iff (rst)
    (ten[1] && !swSel[1] && edgeSel[1]) |-> seqLoadAfterTrig(loadCh[1]))
    else $error("channel 2 trigger did not load after three clocks");

  chk_indep_quiet: assert property (@(posedge clock) disable iff (rst)
    (ten == 2'b11 && !loadCh[1]) |=> $stable(ch2OutputValue))
    else $error("channel 2 output moved without its own load");

  chk_dual_hold: assert property (@(posedge clock) disable iff (rst)
    (holdWrite && ten == 2'b00) |=> (loadCh == 2'b11)
      ##1 (ch1OutputValue == $past(state_ff.hold[0])) && (ch2OutputValue == $past(state_ff.hold[1])))
    else $error("dual holding write did not load both outputs");

  chk_sim_trig: assert property (@(posedge clock) disable iff (rst)
    (ten == 2'b11 && tselCh[0] == tselCh[1] && !swSel[0] && edgeSel[0]) |-> seqBothLoaded)
    else $error("shared trigger did not load both channels together");
endmodule

// ===== ddc_trig_src.sv
`timescale 1ns/1ps
module ddc_trig_src (
  input wire logic clock,
  output logic [7:0] lines
);
  // Lines rest low between events, so every event is a fresh rising edge.
  initial lines = 8'h00;

  task automatic pulse(input logic [7:0] sel, input int len);
    @(posedge clock);
    lines <= sel;
    repeat (len) @(posedge clock);
    lines <= 8'h00;
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb
  import ddc_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [11:0] o1; logic [11:0] o2;} ddc_row_type;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] triggerIn;
  logic [11:0] ch1OutputValue, ch2OutputValue;
  logic [11:0] e1 = 12'h000, e2 = 12'h000;
  int n_fail = 0;
  int n_compared = 0;
  ddc_row_type rows [4] = '{'{OFF_D12R, 32'h0ABC_0123, 12'h123, 12'hABC},
    '{OFF_D12L, 32'hFFF0_8880, 12'h888, 12'hFFF}, '{OFF_D8R, 32'h0000_5AC3, 12'hC30, 12'h5A0},
    '{OFF_D12R, 32'h0000_0FFF, 12'hFFF, 12'h000}};

  ddc_top i_dut (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .triggerIn, .ch1OutputValue, .ch2OutputValue
  );
  ddc_trig_src i_src (
    .clock,
    .lines(triggerIn)
  );

  always #25 clock = ~clock;

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkOut(input logic [11:0] got, input logic [11:0] exp);
    chkWord({20'h0, got}, {20'h0, exp});
  endtask

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    chkWord({30'h0, got}, {30'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awHit, wHit, bHit;
    int i;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bHit = 1'b0;
    for (i = 0; i < 40 && !bHit; i++) begin
      @(negedge clock);
      awHit = s_axi_awvalid && s_axi_awready;
      wHit = s_axi_wvalid && s_axi_wready;
      bHit = s_axi_bvalid && s_axi_bready;
      if (bHit) chkResp(s_axi_bresp, er);
      @(posedge clock);
      if (awHit) s_axi_awvalid <= 1'b0;
      if (wHit) s_axi_wvalid <= 1'b0;
      if (bHit) s_axi_bready <= 1'b0;
    end
    if (!bHit) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic arHit, rHit;
    int i;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rHit = 1'b0;
    for (i = 0; i < 40 && !rHit; i++) begin
      @(negedge clock);
      arHit = s_axi_arvalid && s_axi_arready;
      rHit = s_axi_rvalid && s_axi_rready;
      if (rHit) chkWord(s_axi_rdata, ed);
      if (rHit) chkResp(s_axi_rresp, er);
      @(posedge clock);
      if (arHit) s_axi_arvalid <= 1'b0;
      if (rHit) s_axi_rready <= 1'b0;
    end
    if (!rHit) begin
      n_fail++;
      stop_test();
    end
  endtask

  function automatic logic [15:0] cfg(input logic [2:0] sel, input logic [1:0] wave, input logic [3:0] amp);
    return {4'h0, amp, wave, sel, 1'b1, 2'b00};
  endfunction

  function automatic logic [11:0] sat(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[12] ? 12'hFFF : s[11:0];
  endfunction

  function automatic logic [11:0] msk(input logic [3:0] f);
    return (f > 4'hA) ? 12'hFFF : 12'((13'h0002 << f) - 13'h0001);
  endfunction

  function automatic logic [11:0] nstep(input logic [11:0] v);
    logic [11:0] n;
    n = {v[10:0], v[11] ^ v[5] ^ v[3] ^ v[0]};
    return (n == 12'h000) ? 12'h001 : n;
  endfunction

  task automatic triStep(inout logic [11:0] t, inout logic u, input logic [11:0] amp);
    if (u && t < amp) t = t + 12'h001;
    else if (u) begin
      u = 1'b0;
      t = t - 12'h001;
    end else if (t > 12'h000) t = t - 12'h001;
    else begin
      u = 1'b1;
      t = t + 12'h001;
    end
  endtask

  // The old value must still stand two edges after the event and the new one on the third.
  task automatic fire(input logic [7:0] m, input logic [11:0] n1, input logic [11:0] n2);
    i_src.pulse(m, 1);
    @(posedge clock);
    #1;
    chkOut(ch1OutputValue, e1);
    chkOut(ch2OutputValue, e2);
    @(posedge clock);
    #1;
    chkOut(ch1OutputValue, n1);
    chkOut(ch2OutputValue, n2);
    e1 = n1;
    e2 = n2;
  endtask

  initial begin
    logic [11:0] l, t1, t2;
    logic u1, u2;
    int i;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(rows[i].a, rows[i].d, RESP_OKAY);
      repeat (2) @(posedge clock);
      #1;
      chkOut(ch1OutputValue, rows[i].o1);
      chkOut(ch2OutputValue, rows[i].o2);
      e1 = rows[i].o1;
      e2 = rows[i].o2;
    end
    wr(OFF_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFF_CTRL, CTRL_WMASK, RESP_OKAY);
    rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    wr(8'h10, 32'h0000_0000, RESP_SLVERR);
    wr(OFF_OUT1, 32'h0000_0000, RESP_OKAY);
    rd(OFF_OUT1, {20'h0, e1}, RESP_OKAY);
    wr(OFF_CTRL, {cfg(3'h6, WAVE_OFF, 4'h0), cfg(3'h6, WAVE_OFF, 4'h0)}, RESP_OKAY);
    wr(OFF_D12R, 32'h0456_0789, RESP_OKAY);
    fire(8'h40, 12'h789, 12'h456);
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_CTRL, {cfg(3'h2, 2'h2, 4'h1), cfg(3'h0, 2'h3, 4'h0)}, RESP_OKAY);
    wr(OFF_D12R, 32'h0800_0010, RESP_OKAY);
    t1 = 12'h000;
    t2 = 12'h000;
    u1 = 1'b1;
    u2 = 1'b1;
    for (i = 0; i < 8; i++) begin
      fire(8'h01, sat(12'h010, t1), e2);
      triStep(t1, u1, msk(4'h0));
      fire(8'h04, e1, sat(12'h800, t2));
      triStep(t2, u2, msk(4'h1));
    end
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_CTRL, {cfg(3'h4, 2'h2, 4'h2), cfg(3'h4, 2'h3, 4'h1)}, RESP_OKAY);
    t1 = 12'h000;
    u1 = 1'b1;
    t2 = 12'h000;
    u2 = 1'b1;
    for (i = 0; i < 8; i++) begin
      fire(8'h10, sat(12'h010, t1), sat(12'h800, t2));
      triStep(t1, u1, msk(4'h1));
      triStep(t2, u2, msk(4'h2));
    end
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_CTRL, {cfg(3'h4, WAVE_NOISE, 4'hF), cfg(3'h4, WAVE_NOISE, 4'h3)}, RESP_OKAY);
    wr(OFF_D12R, 32'h0F80_0100, RESP_OKAY);
    l = 12'hAAA;
    for (i = 0; i < 6; i++) begin
      fire(8'h10, sat(12'h100, l & msk(4'h3)), sat(12'hF80, l));
      l = nstep(l);
    end
    wr(OFF_CTRL, {cfg(TSEL_SOFTWARE, WAVE_OFF, 4'h0), cfg(TSEL_SOFTWARE, WAVE_OFF, 4'h0)}, RESP_OKAY);
    wr(OFF_D12R, 32'h0321_0654, RESP_OKAY);
    #1;
    chkOut(ch1OutputValue, e1);
    chkOut(ch2OutputValue, e2);
    wr(OFF_SWTRIG, 32'h0000_0001, RESP_OKAY);
    #1;
    chkOut(ch1OutputValue, 12'h654);
    chkOut(ch2OutputValue, e2);
    wr(OFF_SWTRIG, 32'h0000_0002, RESP_OKAY);
    #1;
    chkOut(ch1OutputValue, 12'h654);
    chkOut(ch2OutputValue, 12'h321);
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1;
    chkOut(ch1OutputValue, 12'h000);
    chkOut(ch2OutputValue, 12'h000);
    rd(OFF_CTRL, CTRL_RESET, RESP_OKAY);
    stop_test();
  end
endmodule
